// ---- include/eras_cfg.svh ----
// constants of the e1 receive overhead and alarm status block
// assumes a 50 mhz system clock and a word-wide ahb-lite register port
`ifndef ERAS_CFG_SVH
`define ERAS_CFG_SVH
// ------------------------------------------------------------------
// clock and times
// ------------------------------------------------------------------
`define ERAS_CLK_HZ        50000000
`define ERAS_CYC_PER_MS    (`ERAS_CLK_HZ / 1000)
`define ERAS_ALARM_MS      100
`define ERAS_T16_MS        3
`define ERAS_SECOND_S      1
`define ERAS_T16_STEPS     22
`define ERAS_LONG_W        23
`define ERAS_SEC_W         26
`define ERAS_IVL_W         13
// ------------------------------------------------------------------
// register indices; byte address is four times the index
// ------------------------------------------------------------------
`define ERAS_IDX_INTL      8'h28
`define ERAS_IDX_EXTRA     8'h29
`define ERAS_IDX_CRC_LO    8'h2a
`define ERAS_IDX_CRC_HI    8'h2b
`define ERAS_IDX_T16       8'h2c
// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define ERAS_BIT_OVR       7
`define ERAS_BIT_FRESH     6
`define ERAS_BIT_T16_EN    6
`define ERAS_BIT_T16_IND   5
`define ERAS_BIT_T16_ALM   4
`define ERAS_ALL_ONES      8'hff
`define ERAS_T16_DECLARE   5'd22
`define ERAS_CRC_MAX       10'h3ff
`define ERAS_HTRANS_NSEQ   2'h2
`endif

// ---- include/eras_pkg.sv ----
// types of the e1 receive overhead and alarm status block
// assumes the line path runs on the same clock as the register port
package eras_pkg;
    // ------------------------------------------------------------------
    // line path indications, all on the system clock
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       out_of_frame_state;       // basic frame alignment lost
        logic       ais_cond;  // out of frame all-ones seen
        logic       oosmf;     // signalling multiframe lost
        logic       crc_err;   // one-cycle crc error pulse
        logic       fas_stb;   // ts0 of alignment frame done
        logic       nfas_stb;  // ts0 of non-alignment frame done
        logic       mf0_stb;   // ts16 of multiframe frame 0 done
        logic       ts16_stb;  // any ts16 byte done
        logic [7:0] ts0_byte;  // line bit 1 in bit 7
        logic [7:0] ts16_byte; // line bit 1 in bit 7
    } eras_line_s;
    typedef logic [7:0] eras_byte_t;
endpackage

// ---- design/eras_top.sv ----
// e1 receive overhead capture, alarm integration and crc second count
// assumes line indications arrive on CLK_SYS; one ahb-lite master
//
// Operation
// - red alarm after 100 ms out of frame
// - all-ones alarm integrated over 100 ms
// - overhead register spans two frames
// - non-alignment ts0 bits map to register
// - overhead register refreshed every non-alignment frame
// - read data latched for whole read
// - ts16 frame 0 bits 5-8 to extras
// - extras register updated once per multiframe
// - 10-bit crc count moved each second
// - fresh flag set on transfer, read clears
// - overrun flag when unread count overwritten
// - own one second timebase for count
// - two all-ones ts16 bytes out of multiframe
// - interval counter declares 22, removes 0
// - slot16 alarm status follows interval counter
// - enabled slot16 change raises interrupt
// - change indication set, cleared by read
// - out of frame follows alignment loss
//
// The AHB-Lite slave port was chosen for this implementation.
`include "eras_cfg.svh"
module eras_top #(
    parameter int unsigned ALARM_CYC = `ERAS_ALARM_MS * `ERAS_CYC_PER_MS,
    parameter int unsigned SEC_CYC   = `ERAS_SECOND_S * `ERAS_CLK_HZ,
    parameter int unsigned IVL_CYC   =
        (`ERAS_T16_MS * `ERAS_CYC_PER_MS) / `ERAS_T16_STEPS
) (
    input  wire logic               CLK_SYS,
    input  wire logic               RST_N,
    input  wire eras_pkg::eras_line_s LINE,
    input  wire logic               HSEL,
    input  wire logic [31:0]        HADDR,
    input  wire logic [1:0]         HTRANS,
    input  wire logic               HWRITE,
    input  wire logic [2:0]         HSIZE,
    input  wire logic [31:0]        HWDATA,
    input  wire logic               HREADY,
    output logic [31:0]             HRDATA,
    output logic                    HREADYOUT,
    output logic                    HRESP,
    output logic                    LOF_ALARM,
    output logic                    ALL_ONES_ALARM,
    output logic                    IRQ
);
    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    // byte address to register index, zero index when off the map
    function automatic logic [7:0] reg_index(input logic [31:0] a);
        logic [7:0] idx;
        idx = a[9:2];
        if (a[1:0] != 2'h0 || a[31:10] != 22'h0)
            idx = 8'h0;
        return idx;
    endfunction

    logic          acc_valid;        // address phase taken
    logic          rd_take;          // read taken this cycle
    logic [7:0]    acc_idx;          // index of address phase
    logic          wr_pend_ff;       // write data phase pending
    logic [7:0]    wr_idx_ff;        // index of pending write
    logic          wr_t16;           // write lands on ts16 register

    assign acc_valid = HSEL && HREADY && (HTRANS == `ERAS_HTRANS_NSEQ);
    assign rd_take   = acc_valid && !HWRITE;
    assign acc_idx   = reg_index(HADDR);
    assign wr_t16    = wr_pend_ff && (wr_idx_ff == `ERAS_IDX_T16);
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    // remember a write address phase for its data phase
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff  <= 8'h0;
        end
        else
        begin
            wr_pend_ff <= acc_valid && HWRITE;
            wr_idx_ff  <= acc_idx;
        end
    end

    // ------------------------------------------------------------------
    // alarm integrators: loss of frame and all-ones
    // ------------------------------------------------------------------
    logic [1:0]                  integ_in;   // raw conditions
    logic [1:0]                  alarm_ff;   // integrated alarms
    logic [`ERAS_LONG_W-1:0]     integ_cnt_ff [2];

    assign integ_in = {LINE.ais_cond, LINE.out_of_frame_state};

    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_integ
            // count while condition differs from the alarm, flip at limit
            always_ff @(posedge CLK_SYS or negedge RST_N)
            begin
                if (!RST_N)
                begin
                    integ_cnt_ff[i] <= '0;
                    alarm_ff[i]     <= 1'b0;
                end
                else if (integ_in[i] == alarm_ff[i])
                    integ_cnt_ff[i] <= '0;
                else if (integ_cnt_ff[i] ==
                         `ERAS_LONG_W'(ALARM_CYC - 1))
                begin
                    integ_cnt_ff[i] <= '0;
                    alarm_ff[i]     <= integ_in[i];
                end
                else
                    integ_cnt_ff[i] <= integ_cnt_ff[i] + 1'b1;
            end
        end
    endgenerate

    assign LOF_ALARM      = alarm_ff[0];
    assign ALL_ONES_ALARM = alarm_ff[1];

    // ------------------------------------------------------------------
    // overhead bit capture
    // ------------------------------------------------------------------
    logic       fas_intl_ff;    // intl bit of last alignment frame
    eras_pkg::eras_byte_t intl_reg_ff;  // international/national bits
    eras_pkg::eras_byte_t extra_reg_ff; // extra bits, low nibble

    // stage the alignment frame bit, load the pair after ts0 of nfas
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            fas_intl_ff <= 1'b0;
            intl_reg_ff <= 8'h0;
        end
        else
        begin
            if (LINE.fas_stb)
                fas_intl_ff <= LINE.ts0_byte[7];
            if (LINE.nfas_stb)
                intl_reg_ff <= {fas_intl_ff, LINE.ts0_byte[7],
                                LINE.ts0_byte[5:0]};
        end
    end

    // line bits 5 to 8 of ts16 in frame 0, once per multiframe
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            extra_reg_ff <= 8'h0;
        else if (LINE.mf0_stb)
            extra_reg_ff <= {4'h0, LINE.ts16_byte[3:0]};
    end

    // ------------------------------------------------------------------
    // crc error count over the block's own second
    // ------------------------------------------------------------------
    logic [`ERAS_SEC_W-1:0] sec_cnt_ff;   // one second timebase
    logic                   sec_tick;     // last cycle of the second
    logic [9:0]             crc_cnt_ff;   // running count
    logic [9:0]             crc_hold_ff;  // count of last second
    logic                   fresh_ff;     // new count not yet read
    logic                   ovr_ff;       // count lost unread
    logic                   rd_crc_hi;    // read of upper count word

    assign sec_tick  = sec_cnt_ff == `ERAS_SEC_W'(SEC_CYC - 1);
    assign rd_crc_hi = rd_take && (acc_idx == `ERAS_IDX_CRC_HI);

    // free running timebase, unaffected by software
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            sec_cnt_ff <= '0;
        else if (sec_tick)
            sec_cnt_ff <= '0;
        else
            sec_cnt_ff <= sec_cnt_ff + 1'b1;
    end

    // saturating count; an error on the tick opens the new second
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            crc_cnt_ff  <= '0;
            crc_hold_ff <= '0;
        end
        else if (sec_tick)
        begin
            crc_hold_ff <= crc_cnt_ff;
            crc_cnt_ff  <= {9'h0, LINE.crc_err};
        end
        else if (LINE.crc_err && crc_cnt_ff != `ERAS_CRC_MAX)
            crc_cnt_ff <= crc_cnt_ff + 1'b1;
    end

    // flags: a transfer wins over the clearing read for fresh; a read on the tick clears overrun
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            fresh_ff <= 1'b0;
            ovr_ff   <= 1'b0;
        end
        else if (sec_tick)
        begin
            fresh_ff <= 1'b1;
            if (fresh_ff && !rd_crc_hi)
                ovr_ff <= 1'b1;
            else if (rd_crc_hi)
                ovr_ff <= 1'b0;
        end
        else if (rd_crc_hi)
        begin
            fresh_ff <= 1'b0;
            ovr_ff   <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // slot 16 all-ones detection and interval alarm
    // ------------------------------------------------------------------
    logic                   ones_prev_ff;  // last ts16 byte all ones
    logic                   t16_det_ff;    // detection level
    logic [`ERAS_IVL_W-1:0] ivl_cnt_ff;    // interval timer
    logic                   ivl_end;       // last cycle of interval
    logic                   ivl_seen_ff;   // detection inside interval
    logic [4:0]             t16_cnt_ff;    // interval counter
    logic                   t16_alm_ff;    // slot16 alarm status
    logic                   nxt_t16_alm;   // next alarm status
    logic                   t16_ind_ff;    // change indication
    logic                   t16_en_ff;     // interrupt enable
    logic                   nxt_t16_en;    // enable after write
    logic                   rd_t16;        // read of ts16 register
    logic                   ts16_ones;     // this byte all ones

    assign ts16_ones = LINE.ts16_byte == `ERAS_ALL_ONES;
    assign ivl_end   = ivl_cnt_ff == `ERAS_IVL_W'(IVL_CYC - 1);
    assign rd_t16    = rd_take && (acc_idx == `ERAS_IDX_T16);

    // two consecutive all-ones bytes while multiframe is lost
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ones_prev_ff <= 1'b0;
            t16_det_ff   <= 1'b0;
        end
        else if (!LINE.oosmf)
        begin
            ones_prev_ff <= 1'b0;
            t16_det_ff   <= 1'b0;
        end
        else if (LINE.ts16_stb)
        begin
            ones_prev_ff <= ts16_ones;
            t16_det_ff   <= ts16_ones && ones_prev_ff;
        end
    end

    // interval timer and presence seen during the interval
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ivl_cnt_ff  <= '0;
            ivl_seen_ff <= 1'b0;
        end
        else if (ivl_end)
        begin
            ivl_cnt_ff  <= '0;
            ivl_seen_ff <= 1'b0;
        end
        else
        begin
            ivl_cnt_ff  <= ivl_cnt_ff + 1'b1;
            ivl_seen_ff <= ivl_seen_ff || t16_det_ff;
        end
    end

    // up on a present interval, down on an absent one
    always_comb
    begin
        nxt_t16_alm = t16_alm_ff;
        if (ivl_end && (ivl_seen_ff || t16_det_ff) &&
            t16_cnt_ff == `ERAS_T16_DECLARE - 5'd1)
            nxt_t16_alm = 1'b1;
        else if (ivl_end && !(ivl_seen_ff || t16_det_ff) &&
                 t16_cnt_ff == 5'd1)
            nxt_t16_alm = 1'b0;
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            t16_cnt_ff <= '0;
            t16_alm_ff <= 1'b0;
        end
        else
        begin
            t16_alm_ff <= nxt_t16_alm;
            if (ivl_end && (ivl_seen_ff || t16_det_ff))
            begin
                if (t16_cnt_ff != `ERAS_T16_DECLARE)
                    t16_cnt_ff <= t16_cnt_ff + 5'd1;
            end
            else if (ivl_end && t16_cnt_ff != 5'd0)
                t16_cnt_ff <= t16_cnt_ff - 5'd1;
        end
    end

    // change indication: a change wins over the clearing read
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            t16_ind_ff <= 1'b0;
        else if (nxt_t16_alm != t16_alm_ff)
            t16_ind_ff <= 1'b1;
        else if (rd_t16)
            t16_ind_ff <= 1'b0;
    end

    // interrupt enable, written in the data phase
    assign nxt_t16_en = wr_t16 ? HWDATA[`ERAS_BIT_T16_EN] : t16_en_ff;

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            t16_en_ff <= 1'b0;
        else
            t16_en_ff <= nxt_t16_en;
    end

    assign IRQ = t16_ind_ff && t16_en_ff;

    // ------------------------------------------------------------------
    // read data, captured at the address phase
    // ------------------------------------------------------------------
    eras_pkg::eras_byte_t rd_mux;  // selected register value

    always_comb
    begin
        rd_mux = 8'h0;
        case (acc_idx)
            `ERAS_IDX_INTL:   rd_mux = intl_reg_ff;
            `ERAS_IDX_EXTRA:  rd_mux = extra_reg_ff;
            `ERAS_IDX_CRC_LO: rd_mux = crc_hold_ff[7:0];
            `ERAS_IDX_CRC_HI:
                rd_mux = {ovr_ff, fresh_ff, 4'h0, crc_hold_ff[9:8]};
            `ERAS_IDX_T16:
                rd_mux = {1'b0, nxt_t16_en, t16_ind_ff, t16_alm_ff, 4'h0};
            default:          rd_mux = 8'h0;
        endcase
    end

    // hold the byte through the data phase
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            HRDATA <= 32'h0;
        else if (rd_take)
            HRDATA <= {24'h0, rd_mux};
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    property p_lof_rise;
        $rose(LOF_ALARM) |-> $past(integ_cnt_ff[0]) ==
            `ERAS_LONG_W'(ALARM_CYC - 1) && $past(LINE.out_of_frame_state);
    endproperty
    a_lof_rise: assert property (p_lof_rise)
        else $error("loss of frame alarm rose early");

    property p_ais_fall;
        $fell(ALL_ONES_ALARM) |-> $past(integ_cnt_ff[1]) ==
            `ERAS_LONG_W'(ALARM_CYC - 1) && !$past(LINE.ais_cond);
    endproperty
    a_ais_fall: assert property (p_ais_fall)
        else $error("all-ones alarm fell early");

    property p_intl_load;
        LINE.nfas_stb |=> intl_reg_ff[6] == $past(LINE.ts0_byte[7]) &&
            intl_reg_ff[4:0] == $past(LINE.ts0_byte[4:0]);
    endproperty
    a_intl_load: assert property (p_intl_load)
        else $error("overhead bits not loaded");

    property p_extra_load;
        LINE.mf0_stb |=> extra_reg_ff[3:0] == $past(LINE.ts16_byte[3:0]);
    endproperty
    a_extra_load: assert property (p_extra_load)
        else $error("extra bits not loaded");

    sequence s_tick;
        sec_tick;
    endsequence
    property p_fresh_set;
        s_tick |=> fresh_ff && crc_hold_ff == $past(crc_cnt_ff);
    endproperty
    a_fresh_set: assert property (p_fresh_set)
        else $error("count transfer missed");

    property p_ovr_set;
        s_tick ##0 (fresh_ff && !rd_crc_hi) |=> ovr_ff;
    endproperty
    a_ovr_set: assert property (p_ovr_set)
        else $error("overrun not flagged");

    property p_t16_cnt;
        t16_cnt_ff <= `ERAS_T16_DECLARE &&
        (t16_alm_ff ? t16_cnt_ff != 5'd0 : 1'b1) &&
        (t16_cnt_ff == `ERAS_T16_DECLARE ? t16_alm_ff : 1'b1);
    endproperty
    a_t16_cnt: assert property (p_t16_cnt)
        else $error("slot16 counter and alarm disagree");

    property p_t16_ind;
        (t16_alm_ff != $past(t16_alm_ff)) |-> t16_ind_ff;
    endproperty
    a_t16_ind: assert property (p_t16_ind)
        else $error("slot16 change not indicated");

    property p_irq;
        (nxt_t16_alm != t16_alm_ff) && nxt_t16_en |=> IRQ;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt does not follow indication");

    property p_det;
        t16_det_ff |-> $past(LINE.oosmf);
    endproperty
    a_det: assert property (p_det)
        else $error("slot16 detect while in multiframe");
endmodule

// ---- sim/eras_line_model.sv ----
// line receive path model: levels, strobes and slot bytes
// assumes the bench calls its tasks right after a rising edge
module eras_line_model (
    input  wire logic            CLK_SYS,
    output eras_pkg::eras_line_s LINE
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // quiet line at time zero
    // ------------------------------------------------------------
    initial
    begin
        LINE = '0;
    end
    // alignment and multiframe levels, held until changed
    task automatic set_lvl(input logic out_of_frame_state, input logic ais,
                           input logic oosmf);
        LINE.out_of_frame_state <= out_of_frame_state;
        LINE.ais_cond <= ais;
        LINE.oosmf <= oosmf;
    endtask
    // one strobe with its byte; byte toggles once released
    // a quiet edge follows so that calls never overlap
    task automatic pulse(input int k, input logic [7:0] b);
        case (k)
            0: LINE.fas_stb <= 1'b1;
            1: LINE.nfas_stb <= 1'b1;
            2: LINE.mf0_stb <= 1'b1;
            default: LINE.crc_err <= 1'b1;
        endcase
        LINE.ts0_byte <= b;
        LINE.ts16_byte <= b;
        LINE.ts16_stb <= (k == 2);
        @(posedge CLK_SYS);
        LINE.fas_stb <= 1'b0;
        LINE.nfas_stb <= 1'b0;
        LINE.mf0_stb <= 1'b0;
        LINE.crc_err <= 1'b0;
        LINE.ts16_stb <= 1'b0;
        LINE.ts0_byte <= ~b;
        LINE.ts16_byte <= ~b;
        @(posedge CLK_SYS);
    endtask
    // slot 16 byte stream, one byte a cycle for n cycles
    task automatic t16(input logic [7:0] b, input int n);
        repeat (n)
        begin
            LINE.ts16_stb <= 1'b1;
            LINE.ts16_byte <= b;
            @(posedge CLK_SYS);
        end
        LINE.ts16_stb <= 1'b0;
        LINE.ts16_byte <= ~b;
        @(posedge CLK_SYS);
    endtask
endmodule

// ---- sim/tb_top.sv ----
// bench: ahb-lite register reads and writes against line scenarios
// assumes short counts: 20 cycle alarms, 64 cycle second, 8 cycle slot
`include "eras_cfg.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk_sys = 1'b0;  // 50 mhz clock
    logic                 rst_n   = 1'b0;  // async reset, low
    eras_pkg::eras_line_s line;            // line indications
    logic [1:0]  htrans = 2'h0;            // bus transfer kind
    logic [31:0] haddr  = 32'h0;           // byte address
    logic        hwrite = 1'b0;            // direction
    logic [31:0] hwdata = 32'h0;           // write data
    logic [31:0] hrdata;                   // read data
    logic        hreadyout;                // slave ready
    logic        lof, aoa, irq;            // alarm outputs
    int          error_cnt    = 0;         // mismatches
    int          total_checks = 0;         // comparisons
    int          n;                        // wait counter
    // ------------------------------------------------------------
    // clock, device and line model
    // ------------------------------------------------------------
    initial
    begin
        forever #10 clk_sys = ~clk_sys;
    end
    eras_top #(.ALARM_CYC(20), .SEC_CYC(64), .IVL_CYC(8)) DUT (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .LINE(line), .HSEL(1'b1),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(),
        .LOF_ALARM(lof), .ALL_ONES_ALARM(aoa), .IRQ(irq));
    eras_line_model u_line (.CLK_SYS(clk_sys), .LINE(line));
    // ------------------------------------------------------------
    // bus cycles and comparison
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, s, e);
        end
    endtask
    // one single word transfer, index times four is the address
    task automatic ahb(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
        htrans <= `ERAS_HTRANS_NSEQ;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= wr;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        rd = hrdata;
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
        logic [31:0] d;
        ahb(1'b0, idx, 32'h0, d);
        chk(d, e);
    endtask
    // poll crc high until the fresh flag shows
    task automatic sync_sec(output logic [31:0] d);
        d = 32'h0;
        n = 0;
        while (d[`ERAS_BIT_FRESH] !== 1'b1 && n < 40)
        begin
            ahb(1'b0, `ERAS_IDX_CRC_HI, 32'h0, d);
            n++;
        end
    endtask
    task automatic end_of_test();
        if (error_cnt == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        end_of_test();
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] d;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        // cleared registers, unmapped word reads zero
        for (int i = 8'h28; i <= 8'h2c; i++)
            if (i != `ERAS_IDX_CRC_HI) rdc(8'(i), 32'h0);
        rdc(8'h3f, 32'h0);
        ahb(1'b1, 8'h3f, 32'hff, d);
        ahb(1'b1, `ERAS_IDX_T16, 32'hff, d);
        rdc(`ERAS_IDX_T16, 32'h40);
        // overhead bits over a frame pair, read twice
        u_line.pulse(0, 8'h80);
        u_line.pulse(1, 8'ha5);
        rdc(`ERAS_IDX_INTL, 32'he5);
        rdc(`ERAS_IDX_INTL, 32'he5);
        u_line.pulse(0, 8'h00);
        u_line.pulse(1, 8'h5a);
        rdc(`ERAS_IDX_INTL, 32'h1a);
        u_line.pulse(2, 8'h3c);
        rdc(`ERAS_IDX_EXTRA, 32'h0c);
        // loss of frame and all-ones integration
        u_line.set_lvl(1'b1, 1'b1, 1'b0);
        repeat (15) @(posedge clk_sys);
        #1 chk({lof, aoa}, 2'b00);
        repeat (10) @(posedge clk_sys);
        #1 chk({lof, aoa}, 2'b11);
        @(posedge clk_sys);
        u_line.set_lvl(1'b0, 1'b0, 1'b0);
        repeat (15) @(posedge clk_sys);
        #1 chk({lof, aoa}, 2'b11);
        repeat (10) @(posedge clk_sys);
        #1 chk({lof, aoa}, 2'b00);
        @(posedge clk_sys);
        // crc count of one second, then an unread overwrite
        ahb(1'b0, `ERAS_IDX_CRC_HI, 32'h0, d);
        sync_sec(d);
        repeat (5) u_line.pulse(3, 8'h00);
        sync_sec(d);
        chk(d, 32'h40);
        rdc(`ERAS_IDX_CRC_LO, 32'h05);
        repeat (140) @(posedge clk_sys);
        rdc(`ERAS_IDX_CRC_HI, 32'hc0);
        rdc(`ERAS_IDX_CRC_HI, 32'h00);
        rdc(`ERAS_IDX_CRC_LO, 32'h00);
        // slot 16 all ones ignored while multiframe is aligned, then alarm raised and removed
        u_line.t16(8'hff, 250);
        rdc(`ERAS_IDX_T16, 32'h40);
        u_line.set_lvl(1'b0, 1'b0, 1'b1);
        u_line.t16(8'hff, 150);
        rdc(`ERAS_IDX_T16, 32'h40);
        n = 0;
        while (irq !== 1'b1 && n < 40)
        begin
            u_line.t16(8'hff, 8);
            n++;
        end
        chk(irq, 1'b1);
        rdc(`ERAS_IDX_T16, 32'h70);
        @(posedge clk_sys);
        #1 chk(irq, 1'b0);
        @(posedge clk_sys);
        u_line.set_lvl(1'b0, 1'b0, 1'b0);
        n = 0;
        while (irq !== 1'b1 && n < 300)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk(irq, 1'b1);
        rdc(`ERAS_IDX_T16, 32'h60);
        end_of_test();
    end
endmodule
